// ### logic/bstap_defines.svh
// constants for the boundary scan test port block
// assumes inclusion by bstap_pkg, bstap_top and the bench
`ifndef BSTAP_DEFINES_SVH
`define BSTAP_DEFINES_SVH
`define BSTAP_IR_W 3
`define BSTAP_BSR_W 109
`define BSTAP_ID_W 32
`define BSTAP_OE_CELL 108
`define BSTAP_IR_EXTEST 3'h0
`define BSTAP_IR_IDENT 3'h1
`define BSTAP_IR_SAMPZ 3'h2
`define BSTAP_IR_SAMPLE 3'h4
`define BSTAP_IR_BYPASS 3'h7
`define BSTAP_IR_CAPTURE 3'h1
`define BSTAP_ID_REV_MSB 31
`define BSTAP_ID_REV_LSB 29
`define BSTAP_ID_PART_MSB 28
`define BSTAP_ID_PART_LSB 12
`define BSTAP_ID_VEND_MSB 11
`define BSTAP_ID_VEND_LSB 1
// identity field values are arbitrary
`define BSTAP_ID_REV 3'h5
`define BSTAP_ID_PART 17'h0a5a5
`define BSTAP_ID_VEND 11'h2aa
`endif

// ### logic/bstap_pkg.sv
// types for the boundary scan test port block
// assumes bstap_defines.svh on the include path
`include "bstap_defines.svh"
package bstap_pkg;
    typedef enum logic [3:0] {
        BSTAP_RESET, BSTAP_IDLE, BSTAP_SEL_DR, BSTAP_CAP_DR, BSTAP_SHIFT_DR,
        BSTAP_EXIT1_DR, BSTAP_PAUSE_DR, BSTAP_EXIT2_DR, BSTAP_UPD_DR,
        BSTAP_SEL_IR, BSTAP_CAP_IR, BSTAP_SHIFT_IR, BSTAP_EXIT1_IR,
        BSTAP_PAUSE_IR, BSTAP_EXIT2_IR, BSTAP_UPD_IR
    } bstap_state_t;
endpackage

// ### logic/bstap_sync.sv
// two flop synchroniser for the test port pins
// assumes pins are asynchronous to clock
`timescale 1ns/100ps
module bstap_sync
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out
);
    logic [3:0] meta_q;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta_q <= 4'h0;
            pin_out <= 4'h0;
        end
        else
        begin
            meta_q <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule

// ### logic/bstap_top.sv
// test access port controller with instruction, bypass, identity and pin chain
// assumes tck slower than clock/4; pins sampled through bstap_sync
// Function
// - identity instruction 001 loads 32-bit identity value and places it on the path
// - instruction 111 puts a one-bit bypass register on the path
// - instruction 010 captures pins, selects chain, floats all memory outputs
// - instruction 100 captures pins into 109-cell chain, selects chain, no disturbance
// - 3-bit instruction; 000 is external test capturing the cell ring
// - identity fields: revision 31:29, part 28:12, vendor 11:1
// - identity bit 0 always reads one
// - cell 108 gates read outputs under external test; presets high
// - external test drives preloaded cell values onto system outputs
// - capture state under sample/preload snapshots pin values into chain
`timescale 1ns/100ps
`include "bstap_defines.svh"
module bstap_top
    import bstap_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [`BSTAP_BSR_W-2:0] pin_state,
    input wire logic [`BSTAP_BSR_W-2:0] sys_out,
    input wire logic sys_oe,
    output logic tdo,
    output logic tdo_oe,
    output logic [`BSTAP_BSR_W-2:0] pin_out,
    output logic pin_oe,
    output logic [`BSTAP_IR_W-1:0] cur_instr
);
    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic [3:0] sync_w;
    logic tck_q, tck_r, tck_f, tms_s, tdi_s, trst_s;

    bstap_sync u_sync
    (
        .clock(clock),
        .reset(reset),
        .pin_in({trst_n, tdi, tms, tck}),
        .pin_out(sync_w)
    );

    assign tms_s = sync_w[1];
    assign tdi_s = sync_w[2];
    assign trst_s = ~sync_w[3];

    always_ff @(posedge clock)
    begin
        if (reset)
            tck_q <= 1'b0;
        else
            tck_q <= sync_w[0];
    end

    assign tck_r = sync_w[0] & ~tck_q;
    assign tck_f = ~sync_w[0] & tck_q;

    // ------------------------------------------------------------
    // controller state
    // ------------------------------------------------------------
    bstap_state_t state_q, state_d;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BSTAP_RESET: state_d = tms_s ? BSTAP_RESET : BSTAP_IDLE;
            BSTAP_IDLE: state_d = tms_s ? BSTAP_SEL_DR : BSTAP_IDLE;
            BSTAP_SEL_DR: state_d = tms_s ? BSTAP_SEL_IR : BSTAP_CAP_DR;
            BSTAP_CAP_DR: state_d = tms_s ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            BSTAP_SHIFT_DR: state_d = tms_s ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            BSTAP_EXIT1_DR: state_d = tms_s ? BSTAP_UPD_DR : BSTAP_PAUSE_DR;
            BSTAP_PAUSE_DR: state_d = tms_s ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
            BSTAP_EXIT2_DR: state_d = tms_s ? BSTAP_UPD_DR : BSTAP_SHIFT_DR;
            BSTAP_UPD_DR: state_d = tms_s ? BSTAP_SEL_DR : BSTAP_IDLE;
            BSTAP_SEL_IR: state_d = tms_s ? BSTAP_RESET : BSTAP_CAP_IR;
            BSTAP_CAP_IR: state_d = tms_s ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            BSTAP_SHIFT_IR: state_d = tms_s ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            BSTAP_EXIT1_IR: state_d = tms_s ? BSTAP_UPD_IR : BSTAP_PAUSE_IR;
            BSTAP_PAUSE_IR: state_d = tms_s ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
            BSTAP_EXIT2_IR: state_d = tms_s ? BSTAP_UPD_IR : BSTAP_SHIFT_IR;
            BSTAP_UPD_IR: state_d = tms_s ? BSTAP_SEL_DR : BSTAP_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_q <= BSTAP_RESET;
        else if (trst_s)
            state_q <= BSTAP_RESET;
        else if (tck_r)
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [`BSTAP_IR_W-1:0] ir_shift_q;

    always_ff @(posedge clock)
    begin
        if (reset || trst_s)
        begin
            ir_shift_q <= `BSTAP_IR_CAPTURE;
            cur_instr <= `BSTAP_IR_IDENT;
        end
        else if (tck_r)
        begin
            if (state_q == BSTAP_RESET)
                cur_instr <= `BSTAP_IR_IDENT;
            else if (state_q == BSTAP_CAP_IR)
                ir_shift_q <= `BSTAP_IR_CAPTURE;
            else if (state_q == BSTAP_SHIFT_IR)
                ir_shift_q <= {tdi_s, ir_shift_q[`BSTAP_IR_W-1:1]};
            else if (state_q == BSTAP_UPD_IR)
                cur_instr <= ir_shift_q;
        end
    end

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic bypass_q;
    logic [`BSTAP_ID_W-1:0] id_q;
    logic [`BSTAP_ID_W-1:0] id_value;
    logic [`BSTAP_BSR_W-1:0] bsr_q, bsr_upd_q, capture_w;
    logic sel_bsr, sel_id;

    assign id_value[`BSTAP_ID_REV_MSB:`BSTAP_ID_REV_LSB] = `BSTAP_ID_REV;
    assign id_value[`BSTAP_ID_PART_MSB:`BSTAP_ID_PART_LSB] = `BSTAP_ID_PART;
    assign id_value[`BSTAP_ID_VEND_MSB:`BSTAP_ID_VEND_LSB] = `BSTAP_ID_VEND;
    assign id_value[0] = 1'b1;

    assign sel_bsr = (cur_instr == `BSTAP_IR_EXTEST) || (cur_instr == `BSTAP_IR_SAMPZ)
        || (cur_instr == `BSTAP_IR_SAMPLE);
    assign sel_id = (cur_instr == `BSTAP_IR_IDENT);
    // pins plus the internal enable cell as last seen
    assign capture_w = {bsr_upd_q[`BSTAP_OE_CELL], pin_state};

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            bypass_q <= 1'b0;
            id_q <= '0;
            bsr_q <= '0;
        end
        else if (tck_r && state_q == BSTAP_CAP_DR)
        begin
            bypass_q <= 1'b0;
            if (sel_id)
                id_q <= id_value;
            if (sel_bsr)
                bsr_q <= capture_w;
        end
        else if (tck_r && state_q == BSTAP_SHIFT_DR)
        begin
            bypass_q <= tdi_s;
            if (sel_id)
                id_q <= {tdi_s, id_q[`BSTAP_ID_W-1:1]};
            if (sel_bsr)
                bsr_q <= {tdi_s, bsr_q[`BSTAP_BSR_W-1:1]};
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset || trst_s)
            bsr_upd_q <= {1'b1, {(`BSTAP_BSR_W-1){1'b0}}};
        else if (tck_r && state_q == BSTAP_RESET)
            bsr_upd_q[`BSTAP_OE_CELL] <= 1'b1;
        else if (tck_r && state_q == BSTAP_UPD_DR && sel_bsr)
            bsr_upd_q <= bsr_q;
    end

    // ------------------------------------------------------------
    // serial output on falling tck
    // ------------------------------------------------------------
    logic shift_w, tdo_d;

    assign shift_w = (state_q == BSTAP_SHIFT_DR) || (state_q == BSTAP_SHIFT_IR);

    always_comb
    begin
        if (state_q == BSTAP_SHIFT_IR)
            tdo_d = ir_shift_q[0];
        else if (sel_bsr)
            tdo_d = bsr_q[0];
        else if (sel_id)
            tdo_d = id_q[0];
        else
            tdo_d = bypass_q;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_f)
        begin
            tdo <= tdo_d;
            tdo_oe <= shift_w;
        end
        else if (trst_s)
            tdo_oe <= 1'b0;
    end

    // ------------------------------------------------------------
    // system output steering
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_out <= '0;
            pin_oe <= 1'b0;
        end
        else if (cur_instr == `BSTAP_IR_EXTEST)
        begin
            pin_out <= bsr_upd_q[`BSTAP_BSR_W-2:0];
            pin_oe <= bsr_upd_q[`BSTAP_OE_CELL];
        end
        else
        begin
            pin_out <= sys_out;
            pin_oe <= sys_oe && (cur_instr != `BSTAP_IR_SAMPZ);
        end
    end
endmodule

// ### tb/bstap_top_assertions.sv
// checks on the test port block outputs
// assumes a bind onto bstap_top
`timescale 1ns/100ps
module bstap_top_assertions
(
    input wire logic clock,
    input wire logic reset,
    input wire logic tck,
    input wire logic [107:0] sys_out,
    input wire logic sys_oe,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [107:0] pin_out,
    input wire logic pin_oe,
    input wire logic [2:0] cur_instr
);
    // ----
    // checks
    // ----
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    AST_IDENT_PASS: assert property ($past(cur_instr) == 3'h1 && !$past(reset) |->
        pin_oe == $past(sys_oe) && pin_out == $past(sys_out)) else $error("ident disturbs");
    AST_BYPASS_PASS: assert property ($past(cur_instr) == 3'h7 && !$past(reset) |->
        pin_oe == $past(sys_oe) && pin_out == $past(sys_out)) else $error("bypass disturbs");
    AST_SAMPLE_PASS: assert property ($past(cur_instr) == 3'h4 && !$past(reset) |->
        pin_oe == $past(sys_oe) && pin_out == $past(sys_out)) else $error("sample disturbs");
    AST_SAMPZ_FLOAT: assert property ($past(cur_instr) == 3'h2 |-> !pin_oe)
        else $error("outputs not floated");
    AST_EXTEST_HOLD: assert property ($past(cur_instr) == 3'h0 && $past(cur_instr, 2) == 3'h0
        && !$past(tck) && !$past(tck, 2) |-> $stable(pin_out)) else $error("extest pins moved");
    AST_RESET_STATE: assert property (disable iff (1'b0) reset |=>
        cur_instr == 3'h1 && !tdo_oe) else $error("reset state wrong");
    AST_TDO_EDGE: assert property ($changed(tdo) |-> $past(tck, 2) == 1'b0)
        else $error("tdo moved with tck high");
    AST_TDO_OE_EDGE: assert property ($changed(tdo_oe) |-> $past(tck, 2) == 1'b0)
        else $error("tdo enable moved with tck high");
    cover property (cur_instr == 3'h0 && pin_oe);
    cover property (cur_instr == 3'h2);
    cover property ($rose(tdo_oe));
endmodule
bind bstap_top bstap_top_assertions u_chk (.clock, .reset, .tck, .sys_out, .sys_oe, .tdo,
    .tdo_oe, .pin_out, .pin_oe, .cur_instr);

// ### tb/bstap_ctrl_model.sv
// board test controller model on the test port pins
// assumes the bench clock; tck stands low between frames
`timescale 1ns/100ps
module bstap_ctrl_model
(
    input wire logic clock,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck = 1'b0,
    output logic tms = 1'b1,
    output logic tdi = 1'b0
);
    logic line_q = 1'b0;
    // ----
    // one tck period, tdo taken at the rise
    // ----
    task automatic step(input logic m, input logic d, output logic so);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clock);
        tck = 1'b1;
        line_q = tdo_oe ? tdo : ~line_q;
        so = line_q;
        repeat (4) @(negedge clock);
        tck = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [108:0] din,
        output logic [108:0] dout);
        logic s;
        dout = '0;
        @(negedge clock);
        step(1'b1, 1'b0, s);
        if (ir)
            step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
        step(1'b0, 1'b0, s);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
    endtask
    task automatic reset5();
        logic s;
        @(negedge clock);
        repeat (5) step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
    endtask
endmodule

// ### tb/tb_bstap_top.sv
// self-checking bench for the test port block
// assumes bstap_ctrl_model drives the test port pins
`timescale 1ns/100ps
`include "bstap_defines.svh"
module tb_bstap_top;
    localparam logic [107:0] PAT = {9{12'ha53}};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sys_oe = 1'b1;
    logic [107:0] pin_state = '0;
    logic [107:0] sys_out = {9{12'h3c5}};
    logic [107:0] pin_out;
    logic [108:0] d;
    logic [2:0] cur_instr;
    logic tck, tms, tdi, tdo, tdo_oe, pin_oe;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    always #20 clock = ~clock;
    bstap_ctrl_model u_ctrl (.clock, .tdo, .tdo_oe, .tck, .tms, .tdi);
    bstap_top DUT (.clock, .reset, .tck, .tms, .tdi, .trst_n(1'b1), .pin_state, .sys_out,
        .sys_oe, .tdo, .tdo_oe, .pin_out, .pin_oe, .cur_instr);
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [108:0] exp, input logic [108:0] got);
        compares++;
        if (exp !== got)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic setir(input logic [2:0] c);
        u_ctrl.scan(1'b1, 3, 109'(c), d);
        chk("ir capture", 109'h1, d & 109'h7);
        chk("instruction", 109'(c), 109'(cur_instr));
    endtask
    task automatic t_ident();
        u_ctrl.reset5();
        chk("power-up instruction", 109'h1, 109'(cur_instr));
        u_ctrl.scan(1'b0, 32, '0, d);
        chk("identity", 109'({`BSTAP_ID_REV, `BSTAP_ID_PART, `BSTAP_ID_VEND}), d >> 1);
        chk("presence bit", 109'h1, d & 109'h1);
        $display("test ident done");
    endtask
    task automatic t_bypass();
        setir(3'h7);
        chk("oe pass", 109'(sys_oe), 109'(pin_oe));
        chk("out pass", 109'(sys_out), 109'(pin_out));
        @(negedge clock);
        sys_oe = 1'b0;
        repeat (2) @(negedge clock);
        chk("oe follow", 109'h0, 109'(pin_oe));
        sys_oe = 1'b1;
        u_ctrl.scan(1'b0, 4, 109'hb, d);
        chk("bypass", 109'h6, d & 109'hf);
        chk("tdo float", 109'h0, 109'(tdo_oe));
        $display("test bypass done");
    endtask
    task automatic t_sample();
        @(negedge clock);
        pin_state = PAT;
        setir(3'h4);
        u_ctrl.scan(1'b0, 109, {1'b0, ~PAT}, d);
        chk("sampled chain", {1'b1, PAT}, d);
        $display("test sample done");
    endtask
    task automatic t_extest();
        setir(3'h0);
        u_ctrl.scan(1'b0, 109, {1'b0, ~PAT}, d);
        chk("extest capture", {1'b0, PAT}, d);
        chk("preloaded outputs", {1'b0, ~PAT}, 109'(pin_out));
        chk("cell 108 gate", 109'h0, 109'(pin_oe));
        u_ctrl.reset5();
        setir(3'h0);
        chk("cell 108 preset", 109'h1, 109'(pin_oe));
        $display("test extest done");
    endtask
    task automatic t_float();
        setir(3'h2);
        chk("float oe", 109'h0, 109'(pin_oe));
        u_ctrl.scan(1'b0, 109, '1, d);
        chk("float chain", {1'b1, PAT}, d);
        $display("test float done");
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        repeat (3) @(negedge clock);
        t_ident();
        t_bypass();
        t_sample();
        t_extest();
        t_float();
        give_verdict();
    end
endmodule
